// ### core/ntec_pkg.sv
package ntec_pkg;

  // ==========================================================================
  // register map (byte addresses on the serial configuration port)
  // ==========================================================================
  localparam logic [14:0] TX_EN_ADDR     = 15'h02f9;
  localparam logic [14:0] OSC_CTRL_ADDR  = 15'h0300;
  localparam logic [14:0] PHASE_MODE_ADDR = 15'h0301;
  localparam logic [14:0] SYNC_CFG_ADDR  = 15'h0302;

  // reset values
  localparam logic [7:0] TX_EN_RST      = 8'h03;
  localparam logic [7:0] OSC_CTRL_RST   = 8'h00;
  localparam logic [7:0] PHASE_MODE_RST = 8'h00;
  localparam logic [7:0] SYNC_CFG_RST   = 8'h00;

  // field positions
  localparam int CHAN_A_BIT      = 0;
  localparam int CHAN_B_BIT      = 1;
  localparam int MIXER_EN_BIT    = 0;
  localparam int SYNTH_EN_BIT    = 1;
  localparam int SELF_COH_BIT    = 2;
  localparam int FAST_RECFG_BIT  = 7;
  localparam int NUM_OSC         = 4;
  // top bit of the sync source field, which starts at bit zero
  localparam int SYNC_SRC_MSB    = 1;

  // writable masks; reserved bits are stored as plain r/w bits
  localparam logic [7:0] TX_EN_MASK = 8'hff;

  // sync source codes
  localparam logic [1:0] SYNC_SRC_IMMEDIATE = 2'h0;
  localparam logic [1:0] SYNC_SRC_SYSREF    = 2'h1;

  // config port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [14:0] addr;
    logic [7:0]  wdata;
  } ntec_req_type;

  // decoded controls going to the upconverter datapath
  typedef struct packed {
    logic                  fast_reconfig_enable;
    logic                  self_coherent_select;
    logic                  synthesis_mode_enable;
    logic                  mixer_enable;
    logic [NUM_OSC-1:0]    phase_mode_field;
    logic [NUM_OSC-1:0]    use_chan0_ref;
    logic [NUM_OSC-1:0]    reseed_on_change;
  } ntec_osc_type;

endpackage

// ### core/ntec_ctrl.sv
`timescale 1ns/1ps
// Contract
// - register bit 1 drives converter B enable
// - register bit 0 drives converter A enable
// - bit 7 hands oscillator control to fast path
// - bit 2 makes phase-coherent oscillators (phase-mode bit clear) use ref 0
// - reference sharing only affects phase-coherent oscillators
// - bit 1 selects direct synthesis once datapath on
// - bit 0 enables mixing with oscillator output
// - set phase-mode bit keeps accumulator on change
// - clear phase-mode bit reseeds accumulator from counter
// - coherent mode restores phase after frequency return
// - source select 0 uses pin, 1 uses register
// - immediate sync fires pending events in one cycle
// - sysref sync defers events to next sysref edge
module ntec_ctrl (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  // serial configuration port, already deserialised
  input  wire ntec_pkg::ntec_req_type req,
  output logic [7:0]                  rdata,
  output logic                        rvalid,
  // enable-source selects from the selection register
  input  wire logic                   chan_a_enable_source_sel,
  input  wire logic                   chan_b_enable_source_sel,
  // external transmit enable pins
  input  wire logic                   chan_a_enable_pin,
  input  wire logic                   chan_b_enable_pin,
  // datapath status and sync trigger
  input  wire logic                   datapath_enable,
  input  wire logic                   sync_trigger,
  input  wire logic                   sysref,
  // outputs to the upconverter datapath
  output logic                        converter_a_tx_en,
  output logic                        converter_b_tx_en,
  output logic                        synthesis_active,
  output ntec_pkg::ntec_osc_type      osc_cfg,
  output logic                        osc_event,
  output logic                        sync_pending
);

  // ==========================================================================
  // elaboration checks
  // ==========================================================================
  // the phase-mode field and its masks share one byte register, so more
  // than eight oscillators cannot be served by this layout
  if (ntec_pkg::NUM_OSC < 1 || ntec_pkg::NUM_OSC > 8) begin : g_bad_osc_count
    $error("oscillator count must lie between 1 and 8");
  end
  // the sync decode compares two-bit source codes
  if (ntec_pkg::SYNC_SRC_MSB != 1) begin : g_bad_sync_field
    $error("sync source field must be two bits wide");
  end

  // ==========================================================================
  // reset release
  // ==========================================================================
  logic rst_meta_reg;
  logic rst_sync_reg;

  // async assert, sync release through two flops; only the second flop feeds
  // the rest of the block, so a release close to an edge never splits state
  // between flops that leave reset one cycle apart
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ==========================================================================
  // register file
  // ==========================================================================
  logic [7:0] tx_en_reg;
  logic [7:0] osc_ctrl_reg;
  logic [7:0] phase_mode_reg;
  logic [7:0] sync_cfg_reg;

  wire hit_tx    = (req.addr == ntec_pkg::TX_EN_ADDR);
  wire hit_osc   = (req.addr == ntec_pkg::OSC_CTRL_ADDR);
  wire hit_phase = (req.addr == ntec_pkg::PHASE_MODE_ADDR);
  wire hit_sync  = (req.addr == ntec_pkg::SYNC_CFG_ADDR);

  // writes store all eight bits, reserved ones included, so software reads
  // back exactly what it wrote; software keeps the datapath off while
  // touching oscillator fields, the block does not police it
  always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      tx_en_reg      <= ntec_pkg::TX_EN_RST;
      osc_ctrl_reg   <= ntec_pkg::OSC_CTRL_RST;
      phase_mode_reg <= ntec_pkg::PHASE_MODE_RST;
      sync_cfg_reg   <= ntec_pkg::SYNC_CFG_RST;
    end else if (req.wr) begin
      if (hit_tx) tx_en_reg <= req.wdata & ntec_pkg::TX_EN_MASK;
      if (hit_osc) osc_ctrl_reg <= req.wdata;
      if (hit_phase) phase_mode_reg <= req.wdata;
      if (hit_sync) sync_cfg_reg <= req.wdata;
    end
  end

  // read mux; unmapped addresses read zero rather than aliasing a neighbour,
  // which keeps a mistyped address visible to software
  logic [7:0] rd_mux;
  assign rd_mux = hit_tx    ? tx_en_reg :
                  hit_osc   ? osc_ctrl_reg :
                  hit_phase ? phase_mode_reg :
                  hit_sync  ? sync_cfg_reg : 8'h00;

  // rdata holds the last read so the host may collect it late; rvalid marks
  // the one cycle in which fresh data arrives
  always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rdata  <= req.rd ? rd_mux : rdata;
      rvalid <= req.rd;
    end
  end

  // ==========================================================================
  // transmit enables
  // ==========================================================================
  // both bits are honoured independently; equal values are software's job
  // pins and selects are sampled every edge with no debounce of their own
  logic tx_a_next;
  logic tx_b_next;
  assign tx_a_next = chan_a_enable_source_sel ? tx_en_reg[ntec_pkg::CHAN_A_BIT]
                                              : chan_a_enable_pin;
  assign tx_b_next = chan_b_enable_source_sel ? tx_en_reg[ntec_pkg::CHAN_B_BIT]
                                              : chan_b_enable_pin;

  // registered enables: one cycle of latency buys glitch-free levels at the
  // converters while a select changes between pin and register bit
  always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      converter_a_tx_en <= 1'b0;
      converter_b_tx_en <= 1'b0;
    end else begin
      converter_a_tx_en <= tx_a_next;
      converter_b_tx_en <= tx_b_next;
    end
  end

  // ==========================================================================
  // oscillator control decode
  // ==========================================================================
  // pure decode of the stored bytes; the datapath sees it one cycle later
  // only the low bits of the phase-mode byte carry meaning
  ntec_pkg::ntec_osc_type osc_next;
  logic [ntec_pkg::NUM_OSC-1:0] cont_bits;
  logic                         sc_bit;
  assign cont_bits = phase_mode_reg[ntec_pkg::NUM_OSC-1:0];
  assign sc_bit    = osc_ctrl_reg[ntec_pkg::SELF_COH_BIT];

  assign osc_next.fast_reconfig_enable  = osc_ctrl_reg[ntec_pkg::FAST_RECFG_BIT];
  assign osc_next.self_coherent_select  = sc_bit;
  assign osc_next.synthesis_mode_enable = osc_ctrl_reg[ntec_pkg::SYNTH_EN_BIT];
  assign osc_next.mixer_enable          = osc_ctrl_reg[ntec_pkg::MIXER_EN_BIT];
  assign osc_next.phase_mode_field      = cont_bits;
  // coherent oscillators reseed from the main counter, which keeps the
  // phase trajectory fixed across a hop and back
  assign osc_next.reseed_on_change      = ~cont_bits;
  // shared reference only for coherent ones; continuous ones never reseed
  assign osc_next.use_chan0_ref         = {ntec_pkg::NUM_OSC{sc_bit}} & ~cont_bits;

  // registered so every field reaches the datapath in the same cycle; a write
  // while the datapath runs can still upset the oscillators, hence the host rule
  always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      osc_cfg          <= '0;
      synthesis_active <= 1'b0;
    end else begin
      osc_cfg          <= osc_next;
      synthesis_active <= osc_next.synthesis_mode_enable & datapath_enable;
    end
  end

  // ==========================================================================
  // sync event generation (serial-port path only)
  // ==========================================================================
  // edge detectors start low, matching the idle level of both inputs, so no
  // false edge follows reset
  logic sysref_d_reg;
  logic trig_d_reg;
  logic pend_reg;
  wire  sysref_rise = sysref & ~sysref_d_reg;
  wire  trig_rise   = sync_trigger & ~trig_d_reg;
  // the fast path owns the events when enabled, so both sources go quiet then
  wire  fr_off      = ~osc_ctrl_reg[ntec_pkg::FAST_RECFG_BIT];
  wire  [1:0] sync_src = sync_cfg_reg[ntec_pkg::SYNC_SRC_MSB:0];
  // codes 2 and 3 are not served: they raise no event at all
  wire  src_imm     = fr_off & (sync_src == ntec_pkg::SYNC_SRC_IMMEDIATE);
  wire  src_sref    = fr_off & (sync_src == ntec_pkg::SYNC_SRC_SYSREF);
  // a trigger rising with sysref waits for the following edge
  wire  fire_sref   = pend_reg & sysref_rise;
  logic pend_next;
  assign pend_next = (src_sref & trig_rise) | (pend_reg & ~sysref_rise & src_sref);

  // all pending events leave as one pulse in a single cycle
  always_ff @(posedge sys_clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      sysref_d_reg <= 1'b0;
      trig_d_reg   <= 1'b0;
      pend_reg     <= 1'b0;
      osc_event    <= 1'b0;
    end else begin
      sysref_d_reg <= sysref;
      trig_d_reg   <= sync_trigger;
      pend_reg     <= pend_next;
      osc_event    <= (src_imm & trig_rise) | (src_sref & fire_sref);
    end
  end

  // exported so software can see a sync that still waits for sysref
  assign sync_pending = pend_reg;

endmodule // ntec_ctrl

// ### verif/ntec_props.sv
`timescale 1ns/1ps
// ==========================================
// port checks beside the control block
module ntec_props (
  // clock, reset and configuration port
  input logic                   sys_clk,
  input logic                   rst_b,
  input ntec_pkg::ntec_req_type req,
  // control inputs
  input logic                   chan_a_enable_source_sel,
  input logic                   chan_b_enable_source_sel,
  input logic                   chan_a_enable_pin,
  input logic                   datapath_enable,
  input logic                   sync_trigger,
  // outputs to the datapath
  input logic                   converter_a_tx_en,
  input logic                   converter_b_tx_en,
  input logic                   synthesis_active,
  input ntec_pkg::ntec_osc_type osc_cfg,
  input logic                   osc_event,
  input logic                   sync_pending
);
  // outputs lag the two-flop reset release, so checks wait four edges
  logic [3:0] up_reg;
  logic [1:0] src_reg;
  wire        live = up_reg[3];
  wire [3:0]  pm   = osc_cfg.phase_mode_field;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      up_reg  <= 4'h0;
      src_reg <= 2'h0;
    end else begin
      up_reg <= {up_reg[2:0], 1'b1};
      if (req.wr && req.addr == ntec_pkg::SYNC_CFG_ADDR) src_reg <= req.wdata[1:0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  property p_pin_a; live && !chan_a_enable_source_sel
    |=> converter_a_tx_en == $past(chan_a_enable_pin); endproperty
  a_pin_a: assert property (p_pin_a) else $error("pin a");
  property p_reg_b; live && chan_b_enable_source_sel && req.wr && req.addr == 15'h02f9
    ##1 chan_b_enable_source_sel |=> converter_b_tx_en == $past(req.wdata[1], 2); endproperty
  a_reg_b: assert property (p_reg_b) else $error("reg b");
  property p_synth; live && $stable(datapath_enable)
    |=> synthesis_active == ($past(datapath_enable) && osc_cfg.synthesis_mode_enable); endproperty
  a_synth: assert property (p_synth) else $error("synth");
  property p_ref; live |->
    osc_cfg.use_chan0_ref == ({4{osc_cfg.self_coherent_select}} & ~pm); endproperty
  a_ref: assert property (p_ref) else $error("ref");
  property p_seed; live |-> osc_cfg.reseed_on_change == ~pm; endproperty
  a_seed: assert property (p_seed) else $error("seed");
  property p_osc; live && req.wr && req.addr == 15'h0300 |=> ##1
    {osc_cfg.fast_reconfig_enable, osc_cfg.mixer_enable} ==
    {$past(req.wdata[7], 2), $past(req.wdata[0], 2)}; endproperty
  a_osc: assert property (p_osc) else $error("osc");
  property p_imm; live && $rose(sync_trigger) && !osc_cfg.fast_reconfig_enable
    && src_reg == 2'h0 |=> osc_event; endproperty
  a_imm: assert property (p_imm) else $error("imm");
  property p_defer; live && $rose(sync_trigger) && !osc_cfg.fast_reconfig_enable
    && src_reg == 2'h1 |=> sync_pending; endproperty
  a_defer: assert property (p_defer) else $error("defer");
endmodule // ntec_props

// ### verif/ntec_host_model.sv
`timescale 1ns/1ps
// ==========================================
// host on the serial configuration port
module ntec_host_model (
  // clock and device status
  input  logic                   sys_clk,
  input  logic                   datapath_enable,
  // configuration port
  input  logic [7:0]             rdata,
  input  logic                   rvalid,
  output ntec_pkg::ntec_req_type req = '0
);
  // strobes last one edge; oscillator set-up writes are dropped while the datapath runs
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    if (datapath_enable && (a == 15'h0300 || a == 15'h0301)) return;
    if (a == 15'h02f9) d[1] = d[0];
    @(posedge sys_clk) req <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk) req <= '0;
  endtask
  // read data is taken at the edge where rvalid stands
  task automatic rd(input logic [14:0] a, output logic [7:0] d);
    @(posedge sys_clk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk) req <= '0;
    @(posedge sys_clk) d = rvalid ? rdata : 8'hxx;
  endtask
endmodule // ntec_host_model

// ### verif/tb_top.sv
`timescale 1ns/1ps
// ==========================================
// bench: register model and output decode
module tb_top;
  logic sys_clk = 1'b0, rst_b = 1'b0, datapath_enable = 1'b0, sync_trigger = 1'b0, sysref = 1'b0;
  logic chan_a_enable_source_sel = 1'b1, chan_b_enable_source_sel = 1'b1;
  logic chan_a_enable_pin = 1'b0, chan_b_enable_pin = 1'b0, rvalid, osc_event, sync_pending;
  logic converter_a_tx_en, converter_b_tx_en, synthesis_active;
  logic [7:0]             rdata, v, mdl [int];
  logic [15:0]            e;
  ntec_pkg::ntec_req_type req;
  ntec_pkg::ntec_osc_type osc_cfg;
  logic [14:0]            adr [$] = '{15'h02f9, 15'h0300, 15'h0301, 15'h0302, 15'h02fa};
  int                     n_fail = 0, comparisons = 0, seed = 43915, r, i, j, n1, n2;
  always #2.5 sys_clk = ~sys_clk;
  ntec_ctrl       i_ntec_ctrl (.*);
  ntec_host_model i_ntec_host_model (.*);
  // one compare for every result
  task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
    comparisons++;
    if (g !== x) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic rd_chk(input logic [14:0] a);
    i_ntec_host_model.rd(a, v);
    chk("rdata", mdl.exists(a) ? mdl[a] : 8'h00, v);
  endtask
  // unmapped places keep nothing
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic held;
    held = datapath_enable && (a == 15'h0300 || a == 15'h0301);
    i_ntec_host_model.wr(a, d);
    if (mdl.exists(a) && !held) mdl[a] = (a == 15'h02f9) ? {d[7:2], d[0], d[0]} : d;
  endtask
  task automatic outs_chk;
    logic exp_a, exp_b;
    exp_a = chan_a_enable_source_sel ? mdl['h2f9][0] : chan_a_enable_pin;
    exp_b = chan_b_enable_source_sel ? mdl['h2f9][1] : chan_b_enable_pin;
    chk("tx_a", exp_a, converter_a_tx_en);
    chk("tx_b", exp_b, converter_b_tx_en);
    chk("synth", mdl['h300][1] & datapath_enable, synthesis_active);
    e = {mdl['h300][7], mdl['h300][2:0], mdl['h301][3:0], {4{mdl['h300][2]}} & ~mdl['h301][3:0],
         ~mdl['h301][3:0]};
    chk("osc", e, osc_cfg);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    for (i = 0; i < 4; i++) mdl[adr[i]] = (i == 0) ? 8'h03 : 8'h00;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    for (i = 0; i < 5; i++) rd_chk(adr[i]);
    $display("test reset values done");
    for (i = 0; i < 20; i++) begin
      r = $random(seed);
      wr(adr[i % 5], r[7:0]);
      rd_chk(adr[i % 5]);
      {chan_a_enable_source_sel, chan_b_enable_source_sel} <= {2{r[8]}};
      {chan_a_enable_pin, chan_b_enable_pin} <= {2{r[9]}};
      repeat (3) @(posedge sys_clk);
      outs_chk;
    end
    // direct synthesis only shows once the datapath runs
    wr(15'h0300, 8'h02);
    datapath_enable <= 1'b1;
    repeat (3) @(posedge sys_clk);
    outs_chk;
    datapath_enable <= 1'b0;
    @(posedge sys_clk);
    $display("test register traffic done");
    // sync cases: immediate, sysref, fast path on, unsupported source
    for (i = 0; i < 4; i++) begin
      wr(15'h0300, {i == 2, 7'h00});
      wr(15'h0302, (i == 3) ? 8'h02 : {7'h00, i[0]});
      repeat (2) @(posedge sys_clk);
      sync_trigger <= 1'b1;
      n1 = 0;
      n2 = 0;
      for (j = 0; j < 12; j++) begin
        @(posedge sys_clk);
        sysref <= (j == 6 || j == 7);
        if (j == 3) chk("pending", i == 1, sync_pending);
        if (osc_event === 1'b1 && j < 6) n1++;
        if (osc_event === 1'b1 && j >= 6) n2++;
      end
      sync_trigger <= 1'b0;
      e = (i == 0) ? 16'h0100 : (i == 1) ? 16'h0001 : 16'h0000;
      chk("events", e, 16'((n1 << 8) | n2));
      $display("test sync case %0d done", i);
    end
    print_verdict;
  end
endmodule // tb_top
bind ntec_ctrl ntec_props i_ntec_props (.*);
